// ==== dioc_pkg.sv ====
// constants, register map and types for discrete i/o channel control
package dioc_pkg;
  localparam int NCH   = 16;
  localparam int NGRP  = 2;
  localparam int GRP_W = 8;
  localparam int IDX_W = 8;
  localparam int SW    = 2 * NCH + 7;
  localparam int SY_OFLT = 16;
  localparam int SY_FUSE = 32;
  localparam int SY_SENS = 34;
  localparam int SY_ACT  = 35;
  localparam int SY_TB   = 36;
  localparam int SY_INT  = 37;
  localparam int SY_EXCH = 38;
  localparam int CLK_MHZ      = 125;
  localparam int TICK_US      = 100;
  localparam int TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int RETRY_S      = 10;
  localparam int RETRY_TICKS  = RETRY_S * 1000000 / TICK_US;
  localparam int FILT_MIN_US  = 100;
  localparam int FILT_STEP_US = 500;
  localparam int TICK_W  = 14;
  localparam int RETRY_W = 17;
  localparam logic [6:0] FILT_MIN_TK  = 7'(FILT_MIN_US / TICK_US);
  localparam logic [6:0] FILT_STEP_TK = 7'(FILT_STEP_US / TICK_US);
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_OUT    = 12'h004;
  localparam logic [11:0] A_FBVAL  = 12'h008;
  localparam logic [11:0] A_REACT  = 12'h00C;
  localparam logic [11:0] A_EDGE   = 12'h010;
  localparam logic [11:0] A_MASK   = 12'h014;
  localparam logic [11:0] A_FILT0  = 12'h018;
  localparam logic [11:0] A_FILT1  = 12'h01C;
  localparam logic [11:0] A_LATCH  = 12'h020;
  localparam logic [11:0] A_INPUT  = 12'h024;
  localparam logic [11:0] A_PEND   = 12'h028;
  localparam logic [11:0] A_STATUS = 12'h02C;
  localparam logic [11:0] A_EVIDX  = 12'h030;
  localparam logic [11:0] A_GTASK  = 12'h034;
  localparam int C_RUN_CMD  = 0;
  localparam int C_STOP_CMD = 1;
  localparam int C_FB_MODE  = 2;
  localparam int C_AUTO     = 3;
  localparam int C_RS_EN    = 4;
  localparam int C_RS_SEL   = 8;
  localparam int EV_SEL     = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_ALL    = 32'h0000_0000;
  typedef enum logic {ST_STOP, ST_RUN} dioc_run_t;
endpackage

// ==== dioc_top.sv ====
// discrete i/o channel control: filters, events, outputs, axi4-lite regs
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dioc_top #(
  parameter int TICK_CYC    = dioc_pkg::TICK_CYC,
  parameter int RETRY_TICKS = dioc_pkg::RETRY_TICKS
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic [11:0]                 s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [11:0]                 s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [dioc_pkg::NCH-1:0]    din,
  input  wire logic [dioc_pkg::NCH-1:0]    out_fault,
  input  wire logic [dioc_pkg::NGRP-1:0]   fuse_blown,
  input  wire logic                        sens_supply_ok,
  input  wire logic                        act_supply_ok,
  input  wire logic                        tblock_present,
  input  wire logic                        int_fault,
  input  wire logic                        exch_fault,
  output logic [dioc_pkg::NCH-1:0]         out_drive,
  output logic                             evt_pulse,
  output logic [dioc_pkg::IDX_W-1:0]       event_handler_index,
  output logic                             run_state
);
  localparam int N  = dioc_pkg::NCH;
  localparam int G  = dioc_pkg::NGRP;
  localparam int GW = dioc_pkg::GRP_W;

  typedef struct packed {
    dioc_pkg::dioc_run_t                run;
    logic [dioc_pkg::SW-1:0]            s1;
    logic [dioc_pkg::SW-1:0]            s2;
    logic [dioc_pkg::SW-1:0]            s3;
    logic [dioc_pkg::SW-1:0]            stab;
    logic [N-1:0]                       filt;
    logic [N-1:0][6:0]                  fcnt;
    logic [N-1:0][3:0]                  fcfg;
    logic [dioc_pkg::TICK_W-1:0]        tick;
    logic [dioc_pkg::RETRY_W-1:0]       retry;
    logic                               fb_mode;
    logic                               auto_react;
    logic                               rs_en;
    logic [3:0]                         rs_sel;
    logic [N-1:0]                       out_val;
    logic [N-1:0]                       fb_val;
    logic [N-1:0]                       edge_rise;
    logic [N-1:0]                       mask;
    logic [N-1:0][dioc_pkg::IDX_W-1:0]  eidx;
    logic [3:0]                         eidx_sel;
    logic [G-1:0][1:0]                  gtask;
    logic [N-1:0]                       latch;
    logic [N-1:0]                       pend;
    logic [G-1:0]                       trip;
    logic [N-1:0]                       drive;
    logic [N-1:0]                       out;
    logic                               evt_pulse;
    logic [dioc_pkg::IDX_W-1:0]         evt_idx;
    logic                               aw_hold;
    logic [11:0]                        aw_addr;
    logic                               w_hold;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    logic                               awready;
    logic                               wready;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               arready;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } dioc_state_t;

  dioc_state_t q_r;
  dioc_state_t q_nxt;

  logic [N-1:0]  din_s;
  logic [N-1:0]  oflt_s;
  logic [G-1:0]  fuse_s;
  logic [N-1:0]  rise;
  logic [N-1:0]  fall;
  logic [N-1:0]  ev_raw;
  logic [N-1:0]  ev;
  logic [N-1:0]  latch_set;
  logic [N-1:0]  latch_clr;
  logic [N-1:0]  pend_clr;
  logic [N-1:0]  trip_mask;
  logic [G-1:0]  grpf;
  logic [G-1:0]  react_req;
  logic [G-1:0]  react_cmd;
  logic          tick_p;
  logic          retry_p;
  logic          wr_go;
  logic          run_cmd;
  logic          stop_cmd;
  logic          rs_rise;
  logic          rs_hold;
  logic [31:0]   wv;
  logic [31:0]   rv;

  assign din_s  = q_r.stab[N-1:0];
  assign oflt_s = q_r.stab[dioc_pkg::SY_OFLT +: N];
  assign fuse_s = q_r.stab[dioc_pkg::SY_FUSE +: G];

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // filter length in 0.1 ms ticks
  function automatic logic [6:0] ftarget(input logic [3:0] code);
    if (code == 4'h0) begin
      return dioc_pkg::FILT_MIN_TK;
    end
    return 7'(7'(code) * dioc_pkg::FILT_STEP_TK);
  endfunction

  always_comb begin
    q_nxt     = q_r;
    wv        = 32'h0000_0000;
    rv        = 32'h0000_0000;
    latch_clr = '0;
    pend_clr  = '0;
    react_cmd = '0;
    run_cmd   = 1'b0;
    stop_cmd  = 1'b0;
    // three-stage sync, level accepted when stages two and three agree
    q_nxt.s1 = {exch_fault, int_fault, tblock_present, act_supply_ok,
                sens_supply_ok, fuse_blown, out_fault, din};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.stab = (q_r.s2 & ~(q_r.s2 ^ q_r.s3)) |
                 (q_r.stab & (q_r.s2 ^ q_r.s3));
    latch_set = q_nxt.stab[N-1:0] & ~din_s;
    // 0.1 ms tick and 10 s retry divider
    tick_p  = (32'(q_r.tick) == TICK_CYC - 1);
    q_nxt.tick = tick_p ? '0 : q_r.tick + 1'b1;
    retry_p = tick_p && (32'(q_r.retry) == RETRY_TICKS - 1);
    if (tick_p) begin
      q_nxt.retry = retry_p ? '0 : q_r.retry + 1'b1;
    end
    // axi4-lite write channel
    if (s_axi_bready && q_r.bvalid) begin
      q_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q_r.awready) begin
      q_nxt.aw_hold = 1'b1;
      q_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_r.wready) begin
      q_nxt.w_hold = 1'b1;
      q_nxt.wdata  = s_axi_wdata;
      q_nxt.wstrb  = s_axi_wstrb;
    end
    wr_go = q_r.aw_hold && q_r.w_hold && !q_r.bvalid;
    if (wr_go) begin
      q_nxt.aw_hold = 1'b0;
      q_nxt.w_hold  = 1'b0;
      q_nxt.bvalid  = 1'b1;
      q_nxt.bresp   = dioc_pkg::RESP_OKAY;
      wv = wmerge(32'h0000_0000, q_r.wdata, q_r.wstrb);
      if (q_r.aw_addr == dioc_pkg::A_CTRL) begin
        wv = wmerge(32'({q_r.rs_sel, 3'b000, q_r.rs_en, q_r.auto_react,
                         q_r.fb_mode, 2'b00}), q_r.wdata, q_r.wstrb);
        run_cmd          = wv[dioc_pkg::C_RUN_CMD];
        stop_cmd         = wv[dioc_pkg::C_STOP_CMD];
        q_nxt.fb_mode    = wv[dioc_pkg::C_FB_MODE];
        q_nxt.auto_react = wv[dioc_pkg::C_AUTO];
        q_nxt.rs_en      = wv[dioc_pkg::C_RS_EN];
        q_nxt.rs_sel     = wv[dioc_pkg::C_RS_SEL +: 4];
      end else if (q_r.aw_addr == dioc_pkg::A_OUT) begin
        q_nxt.out_val = N'(wmerge(32'(q_r.out_val), q_r.wdata, q_r.wstrb));
      end else if (q_r.aw_addr == dioc_pkg::A_FBVAL) begin
        q_nxt.fb_val = N'(wmerge(32'(q_r.fb_val), q_r.wdata, q_r.wstrb));
      end else if (q_r.aw_addr == dioc_pkg::A_REACT) begin
        react_cmd = wv[G-1:0];
      end else if (q_r.aw_addr == dioc_pkg::A_EDGE) begin
        q_nxt.edge_rise = N'(wmerge(32'(q_r.edge_rise), q_r.wdata,
                                    q_r.wstrb));
      end else if (q_r.aw_addr == dioc_pkg::A_MASK) begin
        q_nxt.mask = N'(wmerge(32'(q_r.mask), q_r.wdata, q_r.wstrb));
      end else if (q_r.aw_addr == dioc_pkg::A_FILT0) begin
        q_nxt.fcfg[7:0] = wmerge(q_r.fcfg[7:0], q_r.wdata, q_r.wstrb);
      end else if (q_r.aw_addr == dioc_pkg::A_FILT1) begin
        q_nxt.fcfg[15:8] = wmerge(q_r.fcfg[15:8], q_r.wdata, q_r.wstrb);
      end else if (q_r.aw_addr == dioc_pkg::A_PEND) begin
        pend_clr = wv[N-1:0];
      end else if (q_r.aw_addr == dioc_pkg::A_EVIDX) begin
        if (q_r.wstrb[2]) begin
          q_nxt.eidx_sel = wv[dioc_pkg::EV_SEL +: 4];
        end
        if (q_r.wstrb[0]) begin
          q_nxt.eidx[wv[dioc_pkg::EV_SEL +: 4]] = wv[7:0];
        end
      end else if (q_r.aw_addr == dioc_pkg::A_GTASK) begin
        if (q_r.wstrb[0]) begin
          q_nxt.gtask = wv[2*G-1:0];
        end
      end else if (q_r.aw_addr == dioc_pkg::A_LATCH ||
                   q_r.aw_addr == dioc_pkg::A_INPUT ||
                   q_r.aw_addr == dioc_pkg::A_STATUS) begin
        q_nxt.bresp = dioc_pkg::RESP_OKAY;
      end else begin
        q_nxt.bresp = dioc_pkg::RESP_SLVERR;
      end
    end
    q_nxt.awready = !q_nxt.aw_hold;
    q_nxt.wready  = !q_nxt.w_hold;
    // axi4-lite read channel
    if (s_axi_rready && q_r.rvalid) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q_r.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = dioc_pkg::RESP_OKAY;
      if (s_axi_araddr == dioc_pkg::A_CTRL) begin
        rv = 32'({q_r.rs_sel, 3'b000, q_r.rs_en, q_r.auto_react,
                  q_r.fb_mode, 2'b00});
      end else if (s_axi_araddr == dioc_pkg::A_OUT) begin
        rv = 32'(q_r.out_val);
      end else if (s_axi_araddr == dioc_pkg::A_FBVAL) begin
        rv = 32'(q_r.fb_val);
      end else if (s_axi_araddr == dioc_pkg::A_REACT) begin
        rv = 32'h0000_0000;
      end else if (s_axi_araddr == dioc_pkg::A_EDGE) begin
        rv = 32'(q_r.edge_rise);
      end else if (s_axi_araddr == dioc_pkg::A_MASK) begin
        rv = 32'(q_r.mask);
      end else if (s_axi_araddr == dioc_pkg::A_FILT0) begin
        rv = q_r.fcfg[7:0];
      end else if (s_axi_araddr == dioc_pkg::A_FILT1) begin
        rv = q_r.fcfg[15:8];
      end else if (s_axi_araddr == dioc_pkg::A_LATCH) begin
        rv = 32'(q_r.latch);
        latch_clr = '1;
      end else if (s_axi_araddr == dioc_pkg::A_INPUT) begin
        rv = 32'(q_r.filt);
      end else if (s_axi_araddr == dioc_pkg::A_PEND) begin
        rv = 32'(q_r.pend);
      end else if (s_axi_araddr == dioc_pkg::A_STATUS) begin
        rv = 32'({q_r.trip, 1'b0, (q_r.run == dioc_pkg::ST_RUN),
                  q_r.stab[dioc_pkg::SY_EXCH], q_r.stab[dioc_pkg::SY_INT],
                  |oflt_s, ~q_r.stab[dioc_pkg::SY_TB],
                  ~q_r.stab[dioc_pkg::SY_ACT],
                  ~q_r.stab[dioc_pkg::SY_SENS]});
      end else if (s_axi_araddr == dioc_pkg::A_EVIDX) begin
        rv = 32'({q_r.eidx_sel, 8'h00, q_r.eidx[q_r.eidx_sel]});
      end else if (s_axi_araddr == dioc_pkg::A_GTASK) begin
        rv = 32'(q_r.gtask);
      end else begin
        q_nxt.rresp = dioc_pkg::RESP_SLVERR;
      end
      q_nxt.rdata = rv;
    end
    q_nxt.arready = !q_nxt.rvalid;
    // per channel digital filter
    for (int i = 0; i < N; i++) begin
      if (din_s[i] == q_r.filt[i]) begin
        q_nxt.fcnt[i] = 7'h00;
      end else if (tick_p) begin
        if (q_r.fcnt[i] + 7'h01 >= ftarget(q_r.fcfg[i])) begin
          q_nxt.filt[i] = din_s[i];
          q_nxt.fcnt[i] = 7'h00;
        end else begin
          q_nxt.fcnt[i] = q_r.fcnt[i] + 7'h01;
        end
      end
    end
    // latch and events, set wins over clear
    q_nxt.latch = (q_r.latch & ~latch_clr) | latch_set;
    rise   = q_nxt.filt & ~q_r.filt;
    fall   = ~q_nxt.filt & q_r.filt;
    ev_raw = (rise & q_r.edge_rise) | (fall & ~q_r.edge_rise);
    ev     = ev_raw & ~q_r.mask;
    q_nxt.pend = (q_r.pend & ~pend_clr) | ev;
    q_nxt.evt_pulse = |ev;
    for (int i = N - 1; i >= 0; i--) begin
      if (ev[i]) begin
        q_nxt.evt_idx = q_r.eidx[i];
      end
    end
    // run/stop
    rs_rise = q_r.rs_en && rise[q_r.rs_sel];
    rs_hold = q_r.rs_en && q_r.filt[q_r.rs_sel];
    if (rs_rise || stop_cmd) begin
      q_nxt.run = dioc_pkg::ST_STOP;
    end else if (run_cmd && !rs_hold) begin
      q_nxt.run = dioc_pkg::ST_RUN;
    end
    // group trip and reactivation
    for (int g = 0; g < G; g++) begin
      grpf[g] = (|oflt_s[g*GW +: GW]) | fuse_s[g];
      react_req[g] = react_cmd[g] || (q_r.auto_react && retry_p);
      if (grpf[g]) begin
        q_nxt.trip[g] = 1'b1;
      end else if (react_req[g]) begin
        q_nxt.trip[g] = 1'b0;
      end
      trip_mask[g*GW +: GW] = {GW{q_nxt.trip[g]}};
    end
    // output image
    if (q_r.run == dioc_pkg::ST_RUN) begin
      q_nxt.drive = q_r.out_val;
    end else if (q_r.fb_mode) begin
      q_nxt.drive = q_r.fb_val;
    end
    if (q_r.stab[dioc_pkg::SY_INT]) begin
      q_nxt.out = '0;
    end else begin
      q_nxt.out = q_nxt.drive & ~trip_mask;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= dioc_state_t'(dioc_pkg::RST_ALL);
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready       = q_r.awready;
  assign s_axi_wready        = q_r.wready;
  assign s_axi_bvalid        = q_r.bvalid;
  assign s_axi_bresp         = q_r.bresp;
  assign s_axi_arready       = q_r.arready;
  assign s_axi_rvalid        = q_r.rvalid;
  assign s_axi_rdata         = q_r.rdata;
  assign s_axi_rresp         = q_r.rresp;
  assign out_drive           = q_r.out;
  assign evt_pulse           = q_r.evt_pulse;
  assign event_handler_index = q_r.evt_idx;
  assign run_state           = q_r.run;

  AST_FALLBACK: assert property (@(posedge mclk) disable iff (sys_rst)
    q_r.run == dioc_pkg::ST_STOP && q_r.fb_mode
    |=> q_r.drive == $past(q_r.fb_val))
    else $error("fallback value not applied on stop");
  AST_MAINTAIN: assert property (@(posedge mclk) disable iff (sys_rst)
    q_r.run == dioc_pkg::ST_STOP && !q_r.fb_mode |=> $stable(q_r.drive))
    else $error("maintain mode changed an output");
  AST_INTFLT: assert property (@(posedge mclk) disable iff (sys_rst)
    q_r.stab[dioc_pkg::SY_INT] |=> out_drive == '0)
    else $error("outputs active during internal fault");
  AST_TRIP_GRP: assert property (@(posedge mclk) disable iff (sys_rst)
    q_r.trip[1] |-> out_drive[15:8] == 8'h00)
    else $error("tripped group still drives");
  AST_REACT: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(q_r.trip[0]) |-> !$past(grpf[0]) && $past(react_req[0]))
    else $error("group re-enabled with fault or without request");
  AST_STOP: assert property (@(posedge mclk) disable iff (sys_rst)
    rs_rise ##1 1'b1 |-> run_state == 1'b0)
    else $error("control input stop ignored");
  AST_MASK: assert property (@(posedge mclk) disable iff (sys_rst)
    evt_pulse |-> ((q_r.filt ^ $past(q_r.filt)) & ~$past(q_r.mask)) != '0)
    else $error("event raised without an unmasked filtered edge");
  AST_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    latch_set[0] || (q_r.latch[0] && !latch_clr[0]) |=> q_r.latch[0])
    else $error("latched pulse lost");
  AST_FILTER: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(q_r.filt[0]) |-> $past(tick_p)
    && $past(q_r.fcnt[0]) + 7'h01 >= ftarget($past(q_r.fcfg[0])))
    else $error("filtered input changed before filter time");
endmodule

// ==== dioc_field.sv ====
// field side model: sensors, supplies and output stage feedback
`timescale 1ns/1ps
module dioc_field (
  input  wire logic        mclk,
  input  wire logic [15:0] lvl,
  input  wire logic [15:0] flt,
  input  wire logic [6:0]  cond,
  output logic      [15:0] din = 16'h0000,
  output logic      [15:0] out_fault = 16'h0000,
  output logic      [1:0]  fuse_blown = 2'h0,
  output logic             sens_supply_ok = 1'b1,
  output logic             act_supply_ok = 1'b1,
  output logic             tblock_present = 1'b1,
  output logic             int_fault = 1'b0,
  output logic             exch_fault = 1'b0
);
  // cond: fuses 1:0, supplies/block good 4:2, int 5, exchange 6
  always @(posedge mclk) begin
    din <= lvl;
    out_fault <= flt;
    fuse_blown <= cond[1:0];
    sens_supply_ok <= cond[2];
    act_supply_ok <= cond[3];
    tblock_present <= cond[4];
    int_fault <= cond[5];
    exch_fault <= cond[6];
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for discrete i/o channel control
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, evt_pulse, run_state;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fuse_blown, b_rsp, r_rsp;
  logic [31:0] s_axi_rdata, r_dat;
  logic [15:0] din, out_fault, out_drive;
  logic [15:0] lvl = 16'h0000, flt = 16'h0000;
  logic [6:0]  cond = 7'h1C;
  logic        sens_supply_ok, act_supply_ok, tblock_present;
  logic        int_fault, exch_fault;
  logic [7:0]  event_handler_index, ev_ix;
  int          error_cnt = 0, cmp_count = 0, ev_n, cyc = 0;

  dioc_top #(.TICK_CYC(4), .RETRY_TICKS(8)) DUT (.mclk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .din, .out_fault, .fuse_blown, .sens_supply_ok,
    .act_supply_ok, .tblock_present, .int_fault, .exch_fault,
    .out_drive, .evt_pulse, .event_handler_index, .run_state);
  dioc_field fld (.mclk, .lvl, .flt, .cond, .din, .out_fault,
    .fuse_blown, .sens_supply_ok, .act_supply_ok, .tblock_present,
    .int_fault, .exch_fault);

  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge mclk);
      pa = pa && (s_axi_awready !== 1'b1);
      pw = pw && (s_axi_wready !== 1'b1);
      @(posedge mclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (s_axi_bvalid !== 1'b1) @(negedge mclk);
    b_rsp = s_axi_bresp;
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (s_axi_arready !== 1'b1);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(negedge mclk);
    r_dat = s_axi_rdata;
    r_rsp = s_axi_rresp;
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic evw(input int n);
    ev_n = 0;
    repeat (n) begin
      @(negedge mclk);
      if (evt_pulse === 1'b1) begin
        ev_n++;
        ev_ix = event_handler_index;
      end
    end
  endtask

  task automatic t_regs();
    rd(dioc_pkg::A_CTRL);
    chk(r_dat, 32'h0000_0000);
    rd(12'h100);
    chk({r_dat, r_rsp}, {32'h0000_0000, dioc_pkg::RESP_SLVERR});
    wr(12'h100, 32'hFFFF_FFFF);
    chk(b_rsp, dioc_pkg::RESP_SLVERR);
    wr(dioc_pkg::A_GTASK, 32'h0000_0009);
    rd(dioc_pkg::A_GTASK);
    chk(r_dat, 32'h0000_0009);
  endtask
  task automatic t_stop();
    wr(dioc_pkg::A_OUT, 32'h0000_A5A5);
    wr(dioc_pkg::A_FBVAL, 32'h0000_0F0F);
    wr(dioc_pkg::A_CTRL, 32'h0000_0005);
    settle(4);
    chk({run_state, out_drive}, {1'b1, 16'hA5A5});
    wr(dioc_pkg::A_CTRL, 32'h0000_0006);
    settle(4);
    chk({run_state, out_drive}, {1'b0, 16'h0F0F});
    wr(dioc_pkg::A_CTRL, 32'h0000_0001);
    wr(dioc_pkg::A_OUT, 32'h0000_3C3C);
    wr(dioc_pkg::A_CTRL, 32'h0000_0002);
    wr(dioc_pkg::A_OUT, 32'h0000_FFFF);
    settle(4);
    chk(out_drive, 16'h3C3C);
  endtask
  task automatic t_trip();
    wr(dioc_pkg::A_CTRL, 32'h0000_0001);
    @(posedge mclk) flt <= 16'h0002;
    settle(10);
    chk(out_drive, 16'hFF00);
    rd(dioc_pkg::A_STATUS);
    chk(r_dat, 32'h0000_0148);
    wr(dioc_pkg::A_REACT, 32'h0000_0001);
    settle(4);
    chk(out_drive, 16'hFF00);
    @(posedge mclk) flt <= 16'h0000;
    @(posedge mclk) cond <= 7'h1D;
    settle(10);
    @(posedge mclk) cond <= 7'h1C;
    settle(10);
    chk(out_drive, 16'hFF00);
    wr(dioc_pkg::A_REACT, 32'h0000_0001);
    settle(4);
    chk(out_drive, 16'hFFFF);
    wr(dioc_pkg::A_CTRL, 32'h0000_0009);
    @(posedge mclk) flt <= 16'h0100;
    settle(10);
    chk(out_drive, 16'h00FF);
    @(posedge mclk) flt <= 16'h0000;
    settle(80);
    chk(out_drive, 16'hFFFF);
    @(posedge mclk) cond <= 7'h60;
    settle(10);
    chk(out_drive, 16'h0000);
    rd(dioc_pkg::A_STATUS);
    chk(r_dat, 32'h0000_0077);
    @(posedge mclk) cond <= 7'h1C;
  endtask
  task automatic t_evt();
    wr(dioc_pkg::A_EVIDX, 32'h0000_0080);
    rd(dioc_pkg::A_EVIDX);
    chk(r_dat, 32'h0000_0080);
    wr(dioc_pkg::A_EDGE, 32'h0000_0001);
    @(posedge mclk) lvl[0] <= 1'b1;
    evw(40);
    chk({ev_n, ev_ix}, {32'd1, 8'h80});
    @(posedge mclk) lvl[0] <= 1'b0;
    evw(40);
    chk(ev_n, 0);
    wr(dioc_pkg::A_MASK, 32'h0000_0001);
    @(posedge mclk) lvl[0] <= 1'b1;
    evw(40);
    chk(ev_n, 0);
    wr(dioc_pkg::A_MASK, 32'h0000_0000);
    @(posedge mclk) lvl[0] <= 1'b0;
    settle(30);
    @(posedge mclk) lvl[0] <= 1'b1;
    evw(40);
    chk(ev_n, 1);
    rd(dioc_pkg::A_PEND);
    chk(r_dat, 32'h0000_0001);
    wr(dioc_pkg::A_PEND, 32'h0000_0001);
    rd(dioc_pkg::A_PEND);
    chk(r_dat, 32'h0000_0000);
  endtask
  task automatic t_in();
    rd(dioc_pkg::A_LATCH);
    @(posedge mclk) lvl[2] <= 1'b1;
    repeat (2) @(posedge mclk);
    lvl[2] <= 1'b0;
    settle(8);
    rd(dioc_pkg::A_LATCH);
    chk(r_dat, 32'h0000_0004);
    rd(dioc_pkg::A_LATCH);
    chk(r_dat, 32'h0000_0000);
    wr(dioc_pkg::A_FILT0, 32'h0000_00F0);
    @(posedge mclk) lvl[1] <= 1'b1;
    settle(200);
    rd(dioc_pkg::A_INPUT);
    chk(r_dat & 32'h2, 32'h0);
    settle(120);
    rd(dioc_pkg::A_INPUT);
    chk(r_dat & 32'h2, 32'h2);
  endtask
  task automatic t_rs();
    wr(dioc_pkg::A_CTRL, 32'h0000_0311);
    settle(2);
    chk(run_state, 1'b1);
    @(posedge mclk) lvl[3] <= 1'b1;
    settle(20);
    chk(run_state, 1'b0);
    wr(dioc_pkg::A_CTRL, 32'h0000_0311);
    settle(2);
    chk(run_state, 1'b0);
    @(posedge mclk) lvl[3] <= 1'b0;
    settle(20);
    chk(run_state, 1'b0);
    wr(dioc_pkg::A_CTRL, 32'h0000_0311);
    settle(2);
    chk(run_state, 1'b1);
    rd(dioc_pkg::A_CTRL);
    chk(r_dat, 32'h0000_0310);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    settle(2);
    chk({run_state, out_drive}, 17'h00000);
    t_regs();
    t_stop();
    t_trip();
    t_evt();
    t_in();
    t_rs();
    print_verdict();
  end
endmodule
